/* File: include/psda_pkg.sv */
package psda_pkg;

  // Register bus geometry and byte offsets
  localparam int unsigned AV_ADDR_W       = 4;
  localparam int unsigned AV_DATA_W       = 32;
  localparam logic [3:0]  REG_CORE_CTRL   = 4'h0;
  localparam logic [3:0]  REG_WIN_PAGE    = 4'h4;
  localparam logic [3:0]  REG_TBL_PAGE    = 4'h8;
  localparam logic [3:0]  REG_STATUS      = 4'hc;

  // Field positions and reset values
  localparam int unsigned CTRL_WIN_EN_BIT = 0;
  localparam int unsigned ST_STALL_LSB    = 0;
  localparam int unsigned ST_WINDOW_BIT   = 2;
  localparam int unsigned ST_ZEROED_BIT   = 3;
  localparam int unsigned ST_BUSY_BIT     = 4;
  localparam logic        WIN_EN_RST      = 1'b0;
  localparam logic [7:0]  PAGE_RST        = 8'h00;

  // Data space layout: Y block sits inside the implemented X range
  localparam int unsigned WINDOW_BIT      = 15;
  localparam logic [15:0] DATA_IMPL_END   = 16'h0100;
  localparam logic [15:0] Y_BASE          = 16'h0080;
  localparam logic [15:0] Y_END           = 16'h0100;

  // Added instruction cycles for window accesses
  localparam logic [1:0]  STALL_NONE      = 2'h0;
  localparam logic [1:0]  STALL_SHORT     = 2'h1;
  localparam logic [1:0]  STALL_LONG      = 2'h2;

  typedef enum logic [2:0] {
    OP_DATA_READ,
    OP_DATA_WRITE,
    OP_TABLE_READ_LOW,
    OP_TABLE_READ_HIGH,
    OP_TABLE_WRITE_LOW,
    OP_TABLE_WRITE_HIGH
  } op_t;

  typedef enum logic [2:0] {
    PTR_OTHER,
    PTR_X_POINTER_A,
    PTR_X_POINTER_B,
    PTR_Y_POINTER_A,
    PTR_Y_POINTER_B
  } ptr_t;

  typedef enum logic [1:0] {
    CLS_OTHER,
    CLS_DUAL_MUL_PREFETCH,
    CLS_MOVE,
    CLS_DOUBLE_MOVE
  } instr_cls_t;

  typedef enum logic [5:0] {
    ST_IDLE    = 6'b000001,
    ST_DECODE  = 6'b000010,
    ST_ACCESS  = 6'b000100,
    ST_CAPTURE = 6'b001000,
    ST_STALL   = 6'b010000,
    ST_RESP    = 6'b100000
  } state_t;

  typedef struct packed {
    logic in_loop;
    logic first;
    logic last;
    logic irq_exit;
    logic reentry;
  } repeat_t;

  typedef struct packed {
    logic        valid;
    op_t         op;
    logic        byte_sz;
    logic        table_busy;
    logic [15:0] ea;
    logic [15:0] wdata;
    ptr_t        ptr;
    instr_cls_t  cls;
    repeat_t     rpt;
  } core_req_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] data;
    logic [1:0]  stall;
    logic        zeroed;
    logic        window;
  } core_rsp_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic        config_sp;
    logic [23:0] addr;
    logic [23:0] wdata;
    logic [2:0]  wbe;
  } pm_req_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [1:0]  wbe;
  } dm_req_t;

endpackage

/* File: design/program_space_data_access.sv */
// Overview of operation
// - Program word 24 bits, address steps by two
// - Word low table read returns bits 15:0
// - Byte low read picks byte by select
// - Word high read gives upper byte, zero top
// - Byte high read: upper byte, else phantom zero
// - Upper byte reachable only through high table ops
// - Low table ops reach program word directly
// - Window needs address MSB and enable bit
// - Upper data half maps one 16K-word page
// - Address low 15 bits plus page field
// - Window returns only low 16 program bits
// - Window mapping suspended during table operations
// - Prefetch, move, double move add one cycle
// - Other window instructions add two cycles
// - Loop edges and interrupt exits add two
// - Other loop iterations add no stall
// - X and Y contiguous, Y inside X
// - Non multiply class sees whole composite space
// - Multiply class reads exclude Y from X
// - Multiply class uses dedicated X, Y pointers
// - Table page drives upper bits, bit7 config
// - Wrong region or unimplemented address reads zero
module program_space_data_access (
  input  wire logic                    i_clk_sys,
  input  wire logic                    i_rst_b,
  input  wire logic [3:0]              i_av_address,
  input  wire logic                    i_av_read,
  input  wire logic                    i_av_write,
  input  wire logic [31:0]             i_av_writedata,
  input  wire logic [3:0]              i_av_byteenable,
  output logic      [31:0]             o_av_readdata,
  output logic                         o_av_waitrequest,
  input  wire psda_pkg::core_req_t     i_core_req,
  output logic                         o_core_ready,
  output psda_pkg::core_rsp_t          o_core_rsp,
  output psda_pkg::pm_req_t            o_pm,
  input  wire logic [23:0]             i_pm_rdata,
  output psda_pkg::dm_req_t            o_dm,
  input  wire logic [15:0]             i_dm_rdata
);

  psda_pkg::state_t    state_q;
  psda_pkg::state_t    state_d;
  psda_pkg::core_req_t req_q;
  psda_pkg::core_rsp_t rsp_q;
  psda_pkg::pm_req_t   pm_q;
  psda_pkg::pm_req_t   pm_d;
  psda_pkg::dm_req_t   dm_q;
  psda_pkg::dm_req_t   dm_d;
  logic                ready_q;
  logic                win_en_q;
  logic [7:0]          win_page_q;
  logic [7:0]          tbl_page_q;
  logic [1:0]          stall_left_q;
  logic [15:0]         data_q;
  logic                zeroed_q;
  logic [1:0]          last_stall_q;
  logic                last_window_q;
  logic                last_zeroed_q;
  logic                waitreq_q;
  logic [31:0]         readdata_q;

  // Register bus decode; one wait cycle per access
  wire        av_req      = i_av_read | i_av_write;
  wire        av_take     = av_req & waitreq_q;
  wire        av_wr_done  = i_av_write & ~waitreq_q;
  wire        be_low      = i_av_byteenable[0];
  wire        wr_ctrl     = av_wr_done & be_low & (i_av_address == psda_pkg::REG_CORE_CTRL);
  wire        wr_win_page = av_wr_done & be_low & (i_av_address == psda_pkg::REG_WIN_PAGE);
  wire        wr_tbl_page = av_wr_done & be_low & (i_av_address == psda_pkg::REG_TBL_PAGE);
  wire [31:0] status_word;
  wire [31:0] rd_mux;

  assign status_word = {27'h0000000, ~ready_q, last_zeroed_q, last_window_q, last_stall_q};
  assign rd_mux =
    (i_av_address == psda_pkg::REG_CORE_CTRL) ? {31'h00000000, win_en_q} :
    (i_av_address == psda_pkg::REG_WIN_PAGE)  ? {24'h000000, win_page_q} :
    (i_av_address == psda_pkg::REG_TBL_PAGE)  ? {24'h000000, tbl_page_q} :
    (i_av_address == psda_pkg::REG_STATUS)    ? status_word :
                                                32'h00000000;

  // Operation classes of the captured request
  wire is_data_rd = req_q.op == psda_pkg::OP_DATA_READ;
  wire is_data_wr = req_q.op == psda_pkg::OP_DATA_WRITE;
  wire is_data    = is_data_rd | is_data_wr;
  wire is_trd_lo  = req_q.op == psda_pkg::OP_TABLE_READ_LOW;
  wire is_trd_hi  = req_q.op == psda_pkg::OP_TABLE_READ_HIGH;
  wire is_twr_lo  = req_q.op == psda_pkg::OP_TABLE_WRITE_LOW;
  wire is_twr_hi  = req_q.op == psda_pkg::OP_TABLE_WRITE_HIGH;
  wire is_table   = is_trd_lo | is_trd_hi | is_twr_lo | is_twr_hi;
  wire sel        = req_q.ea[0];

  // Window hit: address MSB plus enable, never while a table op runs
  wire win_hit = is_data & req_q.ea[psda_pkg::WINDOW_BIT] & win_en_q
                 & ~req_q.table_busy;

  // Region checks; Y lies inside the implemented X range
  wire in_y    = (req_q.ea >= psda_pkg::Y_BASE) & (req_q.ea < psda_pkg::Y_END);
  wire x_ptr   = (req_q.ptr == psda_pkg::PTR_X_POINTER_A) |
                 (req_q.ptr == psda_pkg::PTR_X_POINTER_B);
  wire y_ptr   = (req_q.ptr == psda_pkg::PTR_Y_POINTER_A) |
                 (req_q.ptr == psda_pkg::PTR_Y_POINTER_B);
  wire dom_rd  = is_data_rd & (req_q.cls == psda_pkg::CLS_DUAL_MUL_PREFETCH);
  wire wrong_region = dom_rd & ((x_ptr & in_y) | (y_ptr & ~in_y));
  wire unimpl  = is_data & ~win_hit & (req_q.ea >= psda_pkg::DATA_IMPL_END);
  wire zero_rd = is_data_rd & (unimpl | wrong_region);
  wire win_use = win_hit & ~wrong_region;
  // Other classes and all writes see one composite space
  wire dm_use  = is_data & ~win_hit & ~unimpl & ~zero_rd;

  // Stall budget for a window access
  wire short_cls = (req_q.cls == psda_pkg::CLS_DUAL_MUL_PREFETCH) |
                   (req_q.cls == psda_pkg::CLS_MOVE) |
                   (req_q.cls == psda_pkg::CLS_DOUBLE_MOVE);
  wire loop_edge = req_q.rpt.first | req_q.rpt.last |
                   req_q.rpt.irq_exit | req_q.rpt.reentry;
  wire [1:0] stall_loop  = loop_edge ? psda_pkg::STALL_LONG : psda_pkg::STALL_NONE;
  wire [1:0] stall_plain = short_cls ? psda_pkg::STALL_SHORT
                                     : psda_pkg::STALL_LONG;
  wire [1:0] stall_need  = ~win_use ? psda_pkg::STALL_NONE :
                           req_q.rpt.in_loop ? stall_loop : stall_plain;

  // Program addresses; bit 0 is the byte select, never a word bit
  wire [23:0] tbl_addr = {tbl_page_q, req_q.ea};
  wire [23:0] win_addr = {1'b0, win_page_q, req_q.ea[14:0]};
  wire [23:0] pm_addr  = is_table ? tbl_addr : win_addr;

  // Table write lanes; the phantom byte has no storage
  wire [15:0] wr_word     = req_q.byte_sz ? {2{req_q.wdata[7:0]}} : req_q.wdata;
  wire [2:0]  twr_lo_be   = ~req_q.byte_sz ? 3'h3 : (sel ? 3'h2 : 3'h1);
  wire [2:0]  twr_hi_be   = (req_q.byte_sz & sel) ? 3'h0 : 3'h4;
  wire [23:0] twr_lo_data = {8'h00, wr_word};
  wire [23:0] twr_hi_data = {req_q.wdata[7:0], 16'h0000};
  wire [1:0]  dm_be       = ~req_q.byte_sz ? 2'h3 : (sel ? 2'h2 : 2'h1);

  // Read formatting from the program word
  wire [15:0] pm_lo_word = i_pm_rdata[15:0];
  wire [7:0]  pm_lo_byte = sel ? i_pm_rdata[15:8] : i_pm_rdata[7:0];
  wire [7:0]  pm_hi_byte = (req_q.byte_sz & sel) ? 8'h00 : i_pm_rdata[23:16];
  wire [15:0] rd_low     = req_q.byte_sz ? {8'h00, pm_lo_byte} : pm_lo_word;
  wire [15:0] rd_high    = {8'h00, pm_hi_byte};
  wire [7:0]  dm_byte    = sel ? i_dm_rdata[15:8] : i_dm_rdata[7:0];
  wire [15:0] rd_data    = req_q.byte_sz ? {8'h00, dm_byte} : i_dm_rdata;
  wire [15:0] cap_data   = is_trd_hi ? rd_high :
                           (is_trd_lo | win_use) ? rd_low : rd_data;

  // Writes and zero-returned reads answer zero; data_q is still stale at decode
  wire        is_write   = is_data_wr | is_twr_lo | is_twr_hi;
  wire [15:0] rsp_data   = (is_write | (state_q == psda_pkg::ST_DECODE)) ? 16'h0000 :
                           (state_q == psda_pkg::ST_CAPTURE) ? cap_data : data_q;

  // Memory requests built while decoding
  always_comb
  begin
    pm_d           = '0;
    dm_d           = '0;
    pm_d.config_sp = is_table & tbl_page_q[7];
    pm_d.addr      = {pm_addr[23:1], 1'b0};
    dm_d.addr      = req_q.ea;
    dm_d.wdata     = wr_word;
    dm_d.wbe       = dm_be;
    unique case (1'b1)
      is_trd_lo | is_trd_hi:
      begin
        pm_d.req = 1'b1;
      end
      is_twr_lo:
      begin
        pm_d.req   = 1'b1;
        pm_d.we    = 1'b1;
        pm_d.wdata = twr_lo_data;
        pm_d.wbe   = twr_lo_be;
      end
      is_twr_hi:
      begin
        pm_d.req   = |twr_hi_be;
        pm_d.we    = 1'b1;
        pm_d.wdata = twr_hi_data;
        pm_d.wbe   = twr_hi_be;
      end
      is_data:
      begin
        pm_d.req = win_use & is_data_rd; // window is read only
        dm_d.req = dm_use;
        dm_d.we  = is_data_wr;
      end
      default:
      begin
        pm_d.req = 1'b0;
      end
    endcase
  end

  // Sequencer; zero-returning reads skip the memory cycle
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      psda_pkg::ST_IDLE:
      begin
        if (i_core_req.valid)
        begin
          state_d = psda_pkg::ST_DECODE;
        end
      end
      psda_pkg::ST_DECODE:
      begin
        state_d = zero_rd ? psda_pkg::ST_RESP : psda_pkg::ST_ACCESS;
      end
      psda_pkg::ST_ACCESS:
      begin
        state_d = psda_pkg::ST_CAPTURE;
      end
      psda_pkg::ST_CAPTURE:
      begin
        state_d = (stall_left_q != psda_pkg::STALL_NONE) ? psda_pkg::ST_STALL
                                                         : psda_pkg::ST_RESP;
      end
      psda_pkg::ST_STALL:
      begin
        if (stall_left_q == psda_pkg::STALL_SHORT)
        begin
          state_d = psda_pkg::ST_RESP;
        end
      end
      psda_pkg::ST_RESP:
      begin
        state_d = psda_pkg::ST_IDLE;
      end
      default:
      begin
        state_d = psda_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
      state_q <= psda_pkg::ST_IDLE;
    else
      state_q <= state_d;
  end

  // Request capture; core must hold nothing after the accept edge
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
      req_q <= '0;
    else if (state_q == psda_pkg::ST_IDLE && i_core_req.valid)
      req_q <= i_core_req;
  end

  // Ready only in idle; falls on the accept edge
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
      ready_q <= 1'b1;
    else
      ready_q <= (state_d == psda_pkg::ST_IDLE);
  end

  // Memory strobes stand for exactly the access cycle
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
    begin
      pm_q <= '0;
      dm_q <= '0;
    end
    else if (state_q == psda_pkg::ST_DECODE && !zero_rd)
    begin
      pm_q <= pm_d;
      dm_q <= dm_d;
    end
    else
    begin
      pm_q.req <= 1'b0;
      dm_q.req <= 1'b0;
    end
  end

  // Stall counter loaded at decode, spent after the data returns
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
      stall_left_q <= psda_pkg::STALL_NONE;
    else if (state_q == psda_pkg::ST_DECODE)
      stall_left_q <= zero_rd ? psda_pkg::STALL_NONE : stall_need;
    else if (state_q == psda_pkg::ST_STALL)
      stall_left_q <= stall_left_q - psda_pkg::STALL_SHORT;
  end

  // Read data captured one cycle after the memory strobe
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
    begin
      data_q   <= 16'h0000;
      zeroed_q <= 1'b0;
    end
    else if (state_q == psda_pkg::ST_DECODE)
    begin
      data_q   <= 16'h0000;
      zeroed_q <= zero_rd;
    end
    else if (state_q == psda_pkg::ST_CAPTURE && !is_data_wr && !is_twr_lo && !is_twr_hi)
    begin
      data_q <= cap_data;
    end
  end

  // One-cycle answer pulse to the core
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
      rsp_q <= '0;
    else if (state_d == psda_pkg::ST_RESP)
    begin
      rsp_q.valid  <= 1'b1;
      rsp_q.data   <= rsp_data;
      rsp_q.stall  <= stall_need;
      rsp_q.zeroed <= (state_q == psda_pkg::ST_DECODE) ? zero_rd : zeroed_q;
      rsp_q.window <= win_use;
    end
    else
      rsp_q.valid <= 1'b0;
  end

  // Status history of the last finished access
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
    begin
      last_stall_q  <= psda_pkg::STALL_NONE;
      last_window_q <= 1'b0;
      last_zeroed_q <= 1'b0;
    end
    else if (rsp_q.valid)
    begin
      last_stall_q  <= rsp_q.stall;
      last_window_q <= rsp_q.window;
      last_zeroed_q <= rsp_q.zeroed;
    end
  end

  // Software control registers; window decode reads them live, so a write during an access changes its later window decode
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
    begin
      win_en_q   <= psda_pkg::WIN_EN_RST;
      win_page_q <= psda_pkg::PAGE_RST;
      tbl_page_q <= psda_pkg::PAGE_RST;
    end
    else
    begin
      if (wr_ctrl)
        win_en_q <= i_av_writedata[psda_pkg::CTRL_WIN_EN_BIT];
      if (wr_win_page)
        win_page_q <= i_av_writedata[7:0];
      if (wr_tbl_page)
        tbl_page_q <= i_av_writedata[7:0];
    end
  end

  // Waitrequest drops for one cycle per request
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
      waitreq_q <= 1'b1;
    else
      waitreq_q <= ~av_take;
  end

  // Read data latched with the waitrequest drop
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
      readdata_q <= 32'h00000000;
    else if (av_take && i_av_read)
      readdata_q <= rd_mux;
  end

  assign o_av_readdata    = readdata_q;
  assign o_av_waitrequest = waitreq_q;
  assign o_core_ready     = ready_q;
  assign o_core_rsp       = rsp_q;
  assign o_pm             = pm_q;
  assign o_dm             = dm_q;

endmodule

/* File: testbench/psda_mem_model.sv */
// Program and data memory behind the block, answering one cycle after a strobe
module psda_mem_model (
  input  wire logic              i_clk_sys,
  input  wire psda_pkg::pm_req_t i_pm,
  input  wire psda_pkg::dm_req_t i_dm,
  output logic [23:0]            o_pm_rdata = 24'h000000,
  output logic [15:0]            o_dm_rdata = 16'h0000
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle buses toggle every cycle so stale read data can never pass for an answer
  always @(posedge i_clk_sys)
  begin
    o_pm_rdata <= i_pm.req ? {i_pm.addr[7:0] ^ 8'ha5, i_pm.addr[15:0] ^ 16'h5a3c} : ~o_pm_rdata;
    o_dm_rdata <= i_dm.req ? i_dm.addr ^ 16'hc3a5 : ~o_dm_rdata;
  end
endmodule

/* File: testbench/psda_sva.sv */
module psda_sva (
  input wire logic                i_clk_sys,
  input wire logic                i_rst_b,
  input wire logic [3:0]          i_av_address,
  input wire logic                i_av_read,
  input wire logic                i_av_write,
  input wire logic [31:0]         o_av_readdata,
  input wire logic                o_av_waitrequest,
  input wire psda_pkg::core_req_t i_core_req,
  input wire logic                o_core_ready,
  input wire psda_pkg::core_rsp_t o_core_rsp,
  input wire psda_pkg::pm_req_t   o_pm
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);

  // Accepted request, and a multiply-class X-pointer read aimed into the Y block
  wire take = i_core_req.valid && o_core_ready;
  wire mac_y = take && i_core_req.op == psda_pkg::OP_DATA_READ
    && i_core_req.ptr == psda_pkg::PTR_X_POINTER_A
    && i_core_req.cls == psda_pkg::CLS_DUAL_MUL_PREFETCH
    && i_core_req.ea >= psda_pkg::Y_BASE && i_core_req.ea < psda_pkg::Y_END;

  property p_wait_answer;
    (i_av_read || i_av_write) && o_av_waitrequest |=> !o_av_waitrequest;
  endproperty
  a_wait_answer: assert property (p_wait_answer) else $error("bus request not answered");
  property p_wait_one;
    !o_av_waitrequest |=> o_av_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
  property p_unmapped;
    !o_av_waitrequest && i_av_read && i_av_address[1:0] != 2'h0 |-> o_av_readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_ready_drop;
    take |=> !o_core_ready;
  endproperty
  a_ready_drop: assert property (p_ready_drop) else $error("ready stayed high after accept");
  property p_rsp_bound;
    take |-> ##[2:6] o_core_rsp.valid;
  endproperty
  a_rsp_bound: assert property (p_rsp_bound) else $error("core response late");
  property p_rsp_pulse;
    o_core_rsp.valid |-> !o_core_ready ##1 (o_core_ready && !o_core_rsp.valid);
  endproperty
  a_rsp_pulse: assert property (p_rsp_pulse) else $error("response not a ready pulse");
  property p_pm_even;
    o_pm.req |-> o_pm.addr[0] == 1'b0 ##1 !o_pm.req;
  endproperty
  a_pm_even: assert property (p_pm_even) else $error("odd program address");
  property p_mac_zero;
    mac_y |-> ##2 o_core_rsp.valid && o_core_rsp.zeroed && o_core_rsp.data == 16'h0000;
  endproperty
  a_mac_zero: assert property (p_mac_zero) else $error("wrong region read not zero");
  property p_no_win_stall;
    o_core_rsp.valid && !o_core_rsp.window |-> o_core_rsp.stall == psda_pkg::STALL_NONE;
  endproperty
  a_no_win_stall: assert property (p_no_win_stall) else $error("stall without window");
  property p_zero_data;
    o_core_rsp.valid && o_core_rsp.zeroed |-> o_core_rsp.data == 16'h0000;
  endproperty
  a_zero_data: assert property (p_zero_data) else $error("zeroed read with data");

  // Main traffic kinds
  c_long: cover property (o_core_rsp.valid && o_core_rsp.stall == psda_pkg::STALL_LONG);
  c_zeroed: cover property (mac_y);
  c_write: cover property (i_av_write && !o_av_waitrequest);
endmodule

/* File: testbench/tb_program_space_data_access.sv */
module tb_program_space_data_access;
  timeunit 1ns;
  timeprecision 1ps;
  logic                i_clk_sys = 1'b0;
  logic                i_rst_b   = 1'b0;
  logic [3:0]          av_addr   = 4'h0;
  logic                av_rd     = 1'b0;
  logic                av_wr     = 1'b0;
  logic [31:0]         av_wdata  = 32'h0;
  logic [31:0]         av_rdata;
  logic [31:0]         rd_q;
  logic                av_wait;
  logic                core_ready;
  psda_pkg::core_req_t req       = '0;
  psda_pkg::core_rsp_t rsp;
  psda_pkg::core_rsp_t got;
  psda_pkg::pm_req_t   pm;
  psda_pkg::pm_req_t   pm_seen;
  psda_pkg::dm_req_t   dm;
  psda_pkg::dm_req_t   dm_seen;
  logic [23:0]         pm_rdata;
  logic [15:0]         dm_rdata;
  int                  bad_count = 0;
  int                  compares  = 0;

  always #2.5 i_clk_sys = ~i_clk_sys;

  // Byte enable tied: every register field lives in byte 0
  program_space_data_access u_dut (
    .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_av_address(av_addr), .i_av_read(av_rd),
    .i_av_write(av_wr), .i_av_writedata(av_wdata), .i_av_byteenable(4'h1),
    .o_av_readdata(av_rdata), .o_av_waitrequest(av_wait), .i_core_req(req),
    .o_core_ready(core_ready), .o_core_rsp(rsp), .o_pm(pm), .i_pm_rdata(pm_rdata),
    .o_dm(dm), .i_dm_rdata(dm_rdata));
  psda_mem_model u_mem (
    .i_clk_sys(i_clk_sys), .i_pm(pm), .i_dm(dm), .o_pm_rdata(pm_rdata), .o_dm_rdata(dm_rdata));

  task report_and_stop;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task hang;
    chk("wait", 32'h1, 32'h0);
    report_and_stop;
  endtask

  // One Avalon access, held until waitrequest is sampled low
  task av(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    av_addr <= a;
    av_wdata <= d;
    av_wr <= wr;
    av_rd <= !wr;
    for (n = 0; n < 20; n++)
    begin
      @(posedge i_clk_sys);
      rd_q = av_rdata;
      if (!av_wait)
        break;
    end
    if (n == 20)
      hang;
    av_wr <= 1'b0;
    av_rd <= 1'b0;
    @(posedge i_clk_sys); // Idle edge so the next call never re-drives in this step
  endtask

  task rd(input string what, input logic [3:0] a, input logic [31:0] e);
    av(1'b0, a, 32'h0);
    chk(what, e, rd_q);
  endtask

  // One core access; records memory strobes seen until the response pulse
  task core(input psda_pkg::op_t op, input logic bsz, input logic busy, input logic [15:0] ea,
            input psda_pkg::ptr_t ptr, input psda_pkg::instr_cls_t cls, input logic [4:0] rp);
    int n;
    req <= '{1'b1, op, bsz, busy, ea, 16'h6b21, ptr, cls, rp};
    pm_seen = '0;
    dm_seen = '0;
    @(posedge i_clk_sys);
    req.valid <= 1'b0;
    for (n = 0; n < 12; n++)
    begin
      @(posedge i_clk_sys);
      if (pm.req)
        pm_seen = pm;
      if (dm.req)
        dm_seen = dm;
      if (rsp.valid)
        break;
    end
    got = rsp;
    if (n == 12)
      hang;
  endtask

  function automatic logic [23:0] patt(input logic [23:0] a);
    return {a[7:0] ^ 8'ha5, a[15:0] ^ 16'h5a3c};
  endfunction

  task s_regs;
    rd("ctrl reset", psda_pkg::REG_CORE_CTRL, 32'h0);
    rd("page reset", psda_pkg::REG_WIN_PAGE, 32'h0);
    av(1'b1, psda_pkg::REG_WIN_PAGE, 32'h12);
    av(1'b1, psda_pkg::REG_TBL_PAGE, 32'h83);
    av(1'b1, psda_pkg::REG_CORE_CTRL, 32'h1);
    av(1'b1, psda_pkg::REG_STATUS, 32'h1f);
    rd("page", psda_pkg::REG_WIN_PAGE, 32'h12);
    rd("table page", psda_pkg::REG_TBL_PAGE, 32'h83);
    rd("status ro", psda_pkg::REG_STATUS, 32'h0);
    rd("unmapped", 4'h2, 32'h0);
  endtask

  // Low and high reads in both sizes, both byte selects
  task s_table;
    int k;
    logic [15:0] ea;
    logic [15:0] e;
    logic [23:0] p;
    for (k = 0; k < 6; k++)
    begin
      ea = (k == 2 || k == 5) ? 16'h1235 : 16'h1234;
      p = patt({8'h83, ea & 16'hfffe});
      case (k)
        0: e = p[15:0];
        1: e = {8'h00, p[7:0]};
        2: e = {8'h00, p[15:8]};
        5: e = 16'h0000;
        default: e = {8'h00, p[23:16]};
      endcase
      core(k < 3 ? psda_pkg::OP_TABLE_READ_LOW : psda_pkg::OP_TABLE_READ_HIGH, k != 0 && k != 3,
           1'b0, ea, psda_pkg::PTR_OTHER, psda_pkg::CLS_OTHER, 5'h0);
      chk("table data", e, got.data);
      chk("table addr", {8'h83, ea & 16'hfffe}, pm_seen.addr);
      chk("config space", 1'b1, pm_seen.config_sp);
    end
    core(psda_pkg::OP_TABLE_WRITE_LOW, 1'b0, 1'b0, 16'h1234, psda_pkg::PTR_OTHER,
         psda_pkg::CLS_OTHER, 5'h0);
    chk("write low lanes", {1'b1, 3'h3}, {pm_seen.we, pm_seen.wbe});
    chk("write low data", 16'h6b21, pm_seen.wdata[15:0]);
    core(psda_pkg::OP_TABLE_WRITE_HIGH, 1'b0, 1'b0, 16'h1234, psda_pkg::PTR_OTHER,
         psda_pkg::CLS_OTHER, 5'h0);
    chk("write high lanes", {1'b1, 3'h4}, {pm_seen.we, pm_seen.wbe});
  endtask

  // Window reads across all classes, then table-busy and disabled cases
  task s_window;
    int c;
    logic [23:0] p;
    p = patt({1'b0, 8'h12, 15'h0246});
    for (c = 3; c >= 0; c--)
    begin
      core(psda_pkg::OP_DATA_READ, 1'b0, 1'b0, 16'h8246, psda_pkg::PTR_X_POINTER_A,
           psda_pkg::instr_cls_t'(c), 5'h0);
      chk("window addr", {1'b0, 8'h12, 15'h0246}, pm_seen.addr);
      chk("window data", p[15:0], got.data);
      chk("window stall", c == 0 ? 2'h2 : 2'h1, got.stall);
    end
    rd("status", psda_pkg::REG_STATUS, 32'h6);
    core(psda_pkg::OP_DATA_READ, 1'b0, 1'b1, 16'h8246, psda_pkg::PTR_OTHER,
         psda_pkg::CLS_OTHER, 5'h0);
    chk("busy window", 18'h10000, {got.window, got.zeroed, got.data});
    av(1'b1, psda_pkg::REG_CORE_CTRL, 32'h0);
    core(psda_pkg::OP_DATA_READ, 1'b0, 1'b0, 16'h8246, psda_pkg::PTR_OTHER,
         psda_pkg::CLS_OTHER, 5'h0);
    chk("off window", 18'h10000, {got.window, got.zeroed, got.data});
    av(1'b1, psda_pkg::REG_CORE_CTRL, 32'h1);
  endtask

  // Loop edges cost two cycles, steady iterations none
  task s_repeat;
    int k;
    for (k = 0; k < 5; k++)
    begin
      core(psda_pkg::OP_DATA_READ, 1'b0, 1'b0, 16'h8246, psda_pkg::PTR_OTHER,
           psda_pkg::CLS_MOVE, k == 4 ? 5'h10 : 5'h10 | (5'h08 >> k));
      chk("loop stall", k == 4 ? 2'h0 : 2'h2, got.stall);
    end
  endtask

  task s_mac;
    core(psda_pkg::OP_DATA_READ, 1'b0, 1'b0, 16'h0090, psda_pkg::PTR_X_POINTER_A,
         psda_pkg::CLS_DUAL_MUL_PREFETCH, 5'h0);
    chk("x ptr in y", 17'h10000, {got.zeroed, got.data});
    core(psda_pkg::OP_DATA_READ, 1'b0, 1'b0, 16'h0040, psda_pkg::PTR_Y_POINTER_A,
         psda_pkg::CLS_DUAL_MUL_PREFETCH, 5'h0);
    chk("y ptr in x", 17'h10000, {got.zeroed, got.data});
    core(psda_pkg::OP_DATA_READ, 1'b0, 1'b0, 16'h0090, psda_pkg::PTR_Y_POINTER_B,
         psda_pkg::CLS_DUAL_MUL_PREFETCH, 5'h0);
    chk("y ptr in y", 16'h0090 ^ 16'hc3a5, got.data);
    core(psda_pkg::OP_DATA_READ, 1'b0, 1'b0, 16'h0090, psda_pkg::PTR_OTHER,
         psda_pkg::CLS_OTHER, 5'h0);
    chk("composite", 16'h0090 ^ 16'hc3a5, got.data);
    core(psda_pkg::OP_DATA_READ, 1'b0, 1'b0, 16'h0300, psda_pkg::PTR_OTHER,
         psda_pkg::CLS_OTHER, 5'h0);
    chk("unimplemented", 17'h10000, {got.zeroed, got.data});
    core(psda_pkg::OP_DATA_WRITE, 1'b0, 1'b0, 16'h0090, psda_pkg::PTR_X_POINTER_A,
         psda_pkg::CLS_DUAL_MUL_PREFETCH, 5'h0);
    chk("mac write", {1'b1, 2'h3, 16'h0090}, {dm_seen.we, dm_seen.wbe, dm_seen.addr});
    chk("mac write data", 16'h6b21, dm_seen.wdata);
  endtask

  initial
  begin
    repeat (8) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    @(posedge i_clk_sys);
    s_regs;
    s_table;
    s_window;
    s_repeat;
    s_mac;
    report_and_stop;
  end
endmodule

bind program_space_data_access psda_sva u_sva (
  .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_av_address(i_av_address),
  .i_av_read(i_av_read), .i_av_write(i_av_write), .o_av_readdata(o_av_readdata),
  .o_av_waitrequest(o_av_waitrequest), .i_core_req(i_core_req), .o_core_ready(o_core_ready),
  .o_core_rsp(o_core_rsp), .o_pm(o_pm));
